// ---- logic/dic_dedicated_input_control.sv ----
// Behaviour
// [RULE_01] Off mode ignores interlock input
// [RULE_02] Gate mode: enable only while shorted
// [RULE_03] Gate mode: opening while enabled faults
// [RULE_04] Force mode: output follows shorted interlock
// [RULE_05] Armed transient starts on trigger rise
// [RULE_06] Waiting transient shows running, zero progress
// [RULE_07] Only phase A locks; B, C follow
// [RULE_08] Track setpoint plus/minus span; span resets 10Hz
// [RULE_09] Sync rising edge, 15 to 5000 Hz
// [RULE_10] Reacquire before lock; unlocked meanwhile
// [RULE_11] Lock status answers a query
// [RULE_12] Locked shown one second in three
// [RULE_13] Programmable phase offset to reference
// [RULE_14] Programmable loop tracking speed
// [RULE_15] Operator sets setpoint near reference
// [RULE_16] Operator avoids enabling while unlocked
// [RULE_17] Two-stage synchronizers on all inputs
// [RULE_18] Input high at 12V means shorted
module dic_dedicated_input_control
  import dic_pkg::*;
#(
  parameter int unsigned DISP_PERIOD_C = DISP_PERIOD_CYC,
  parameter int unsigned DISP_SHOW_C = DISP_SHOW_CYC,
  parameter int unsigned REF_PMAX_C = REF_PMAX_CYC,
  parameter int unsigned REF_PMIN_C = REF_PMIN_CYC
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire dic_cfg_t cfg_i,
  input wire logic [15:0] capture_span_i,
  input wire logic capture_span_wr_i,
  input wire logic interlock_input_i,
  input wire logic transient_trigger_input_i,
  input wire logic sync_reference_i,
  input wire logic enable_req_i,
  input wire logic disable_req_i,
  input wire logic fault_clear_i,
  input wire logic transient_arm_i,
  input wire logic transient_done_i,
  input wire logic sync_query_i,
  output logic output_enable_o,
  output logic interlock_fault_o,
  output logic transient_running_o,
  output logic transient_progress_zero_o,
  output logic transient_start_o,
  output logic sync_locked_o,
  output logic sync_query_valid_o,
  output logic sync_query_locked_o,
  output logic status_show_synced_o,
  output logic [31:0] phase_a_o,
  output logic [31:0] phase_b_o,
  output logic [31:0] phase_c_o
);
  // ----------------------------------------
  // Input synchronizers
  // ----------------------------------------
  logic [2:0] pin_raw;
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic [2:0] prev_q;
  logic il_s;
  logic trig_rise;
  logic ref_rise;
  assign pin_raw = {sync_reference_i, transient_trigger_input_i,
                    interlock_input_i};
  // Two flops per pin, third stage for edges
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      prev_q <= 3'h0;
    end else begin
      meta_q <= pin_raw; // RULE_17
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end
  assign il_s = sync_q[0]; // RULE_18
  assign trig_rise = sync_q[1] & ~prev_q[1]; // RULE_05
  assign ref_rise = sync_q[2] & ~prev_q[2]; // RULE_09
  // ----------------------------------------
  // Interlock and output enable
  // ----------------------------------------
  logic en_d, en_q, flt_d, flt_q;
  // Next enable and fault per interlock mode
  always_comb begin
    en_d = en_q;
    flt_d = flt_q && !fault_clear_i;
    unique case (cfg_i.il_mode)
      DIC_IL_GATE: begin
        if (en_q && !il_s) begin
          en_d = 1'b0; // RULE_03
          flt_d = 1'b1; // RULE_03
        end else if (disable_req_i) begin
          en_d = 1'b0;
        end else if (enable_req_i && il_s && !flt_q) begin
          en_d = 1'b1; // RULE_02
        end
      end
      DIC_IL_FORCE: begin
        en_d = il_s; // RULE_04
      end
      default: begin
        if (disable_req_i) begin
          en_d = 1'b0;
        end else if (enable_req_i) begin
          en_d = 1'b1; // RULE_01
        end
      end
    endcase
  end
  // Enable and fault registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      en_q <= 1'b0;
      flt_q <= 1'b0;
    end else begin
      en_q <= en_d;
      flt_q <= flt_d;
    end
  end
  assign output_enable_o = en_q;
  assign interlock_fault_o = flt_q;
  // ----------------------------------------
  // Transient trigger
  // ----------------------------------------
  dic_tr_state_t tr_d, tr_q;
  logic start_d, start_q, run_d, run_q, zero_d, zero_q;
  // Arm, wait for edge, run
  always_comb begin
    tr_d = tr_q;
    start_d = 1'b0;
    unique case (tr_q)
      DIC_TR_IDLE: begin
        if (transient_arm_i && cfg_i.trig_mode) begin
          tr_d = DIC_TR_WAIT; // RULE_05
        end else if (transient_arm_i) begin
          tr_d = DIC_TR_RUN;
          start_d = 1'b1;
        end
      end
      DIC_TR_WAIT: begin
        if (transient_done_i) begin
          tr_d = DIC_TR_IDLE;
        end else if (trig_rise) begin
          tr_d = DIC_TR_RUN; // RULE_05
          start_d = 1'b1;
        end
      end
      DIC_TR_RUN: begin
        if (transient_done_i) begin
          tr_d = DIC_TR_IDLE;
        end
      end
      default: tr_d = DIC_TR_IDLE;
    endcase
    // Status flags follow the next state so they come from flops
    run_d = (tr_d != DIC_TR_IDLE); // RULE_06
    zero_d = (tr_d == DIC_TR_WAIT); // RULE_06
  end
  // Transient state registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tr_q <= DIC_TR_IDLE;
      start_q <= 1'b0;
      run_q <= 1'b0;
      zero_q <= 1'b0;
    end else begin
      tr_q <= tr_d;
      start_q <= start_d;
      run_q <= run_d;
      zero_q <= zero_d;
    end
  end
  assign transient_running_o = run_q; // RULE_06
  assign transient_progress_zero_o = zero_q; // RULE_06
  assign transient_start_o = start_q;
  // ----------------------------------------
  // Sync loop
  // ----------------------------------------
  logic [15:0] span_d, span_q;
  logic [23:0] cnt_d, cnt_q, per_d, per_q;
  logic [31:0] acc_d, acc_q, inc_d, inc_q;
  logic [3:0] good_d, good_q;
  logic lock_d, lock_q, sen_q;
  logic [16:0] f_lo, f_hi;
  logic [40:0] prod_lo, prod_hi;
  logic [31:0] inc_nom, inc_lo, inc_hi, err, err_abs, inc_adj;
  logic [4:0] shift;
  logic hw_ok, band_ok, steady, good_edge, ref_lost;
  // Capture band and nominal increments
  always_comb begin
    f_hi = {1'b0, cfg_i.frequency_setpoint} + {1'b0, span_q};
    f_lo = (cfg_i.frequency_setpoint > span_q) ?
      {1'b0, cfg_i.frequency_setpoint - span_q} : 17'h00000;
    prod_lo = 41'(cnt_q) * 41'(f_lo);
    prod_hi = 41'(cnt_q) * 41'(f_hi);
    band_ok = (prod_lo <= 41'(CLK_HZ)) && (prod_hi >= 41'(CLK_HZ));
    hw_ok = (cnt_q >= 24'(REF_PMIN_C)) && (cnt_q <= 24'(REF_PMAX_C));
    inc_nom = 32'((48'(cfg_i.frequency_setpoint) * 48'(INC_PER_HZ))
      >> INC_FRAC);
    inc_lo = 32'((48'(f_lo) * 48'(INC_PER_HZ)) >> INC_FRAC);
    inc_hi = 32'((48'(f_hi) * 48'(INC_PER_HZ)) >> INC_FRAC);
    err = acc_q - cfg_i.reference_phase_offset; // RULE_13
    err_abs = err[31] ? (~err + 32'h0000_0001) : err;
    steady = ((cnt_q > per_q) ? (cnt_q - per_q) : (per_q - cnt_q))
      <= PERIOD_TOL;
    good_edge = hw_ok && band_ok && steady && (err_abs < LOCK_ERR_MAX);
    ref_lost = (cnt_q >= 24'(REF_PMAX_C));
    shift = SHIFT_BASE + {1'b0, 4'hF - cfg_i.track_speed}; // RULE_14
    inc_adj = inc_q - 32'($signed(err) >>> shift);
  end
  // Period, phase accumulator and lock tracking
  always_comb begin
    span_d = capture_span_wr_i ? capture_span_i : span_q;
    cnt_d = ref_rise ? 24'h000001 : (ref_lost ? cnt_q : cnt_q + 24'h1);
    per_d = ref_rise ? cnt_q : per_q;
    acc_d = acc_q + inc_q;
    inc_d = inc_q;
    good_d = good_q;
    lock_d = lock_q;
    if (!cfg_i.sync_en || !sen_q) begin
      inc_d = inc_nom;
      good_d = 4'h0; // RULE_10
      lock_d = 1'b0; // RULE_10
    end else if (ref_lost) begin
      good_d = 4'h0;
      lock_d = 1'b0;
    end else if (ref_rise && hw_ok && band_ok) begin
      // Only phase A is pulled toward the reference
      acc_d = acc_q + inc_q - 32'($signed(err) >>> PHASE_PULL); // RULE_07
      if (inc_adj < inc_lo) begin
        inc_d = inc_lo; // RULE_08
      end else if (inc_adj > inc_hi) begin
        inc_d = inc_hi; // RULE_08
      end else begin
        inc_d = inc_adj;
      end
      if (!good_edge) begin
        good_d = 4'h0; // RULE_10
        lock_d = 1'b0;
      end else if (good_q < LOCK_EDGES) begin
        good_d = good_q + 4'h1;
      end else begin
        lock_d = 1'b1; // RULE_10
      end
    end else if (ref_rise) begin
      inc_d = inc_nom; // RULE_08
      good_d = 4'h0;
      lock_d = 1'b0;
    end
  end
  // Sync loop registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      span_q <= CAPTURE_SPAN_RST; // RULE_08
      cnt_q <= 24'h000000;
      per_q <= 24'h000000;
      acc_q <= 32'h0000_0000;
      inc_q <= 32'h0000_0000;
      good_q <= 4'h0;
      lock_q <= 1'b0;
      sen_q <= 1'b0;
    end else begin
      span_q <= span_d;
      cnt_q <= cnt_d;
      per_q <= per_d;
      acc_q <= acc_d;
      inc_q <= inc_d;
      good_q <= good_d;
      lock_q <= lock_d;
      sen_q <= cfg_i.sync_en;
    end
  end
  // ----------------------------------------
  // Phases, status display and query
  // ----------------------------------------
  logic [31:0] disp_d, disp_q, pb_d, pb_q, pc_d, pc_q;
  logic show_d, show_q, qv_q, ql_q;
  // Display cadence and phase B/C derivation
  always_comb begin
    disp_d = !lock_d ? 32'h0000_0000 :
      ((disp_q >= 32'(DISP_PERIOD_C - 1)) ? 32'h0000_0000 :
      disp_q + 32'h0000_0001);
    show_d = lock_d && (disp_d < 32'(DISP_SHOW_C)); // RULE_12
    pb_d = acc_d + cfg_i.angle_b; // RULE_07
    pc_d = acc_d + cfg_i.angle_c; // RULE_07
  end
  // Output registers
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      disp_q <= 32'h0000_0000;
      show_q <= 1'b0;
      pb_q <= 32'h0000_0000;
      pc_q <= 32'h0000_0000;
      qv_q <= 1'b0;
      ql_q <= 1'b0;
    end else begin
      disp_q <= disp_d;
      show_q <= show_d;
      pb_q <= pb_d;
      pc_q <= pc_d;
      qv_q <= sync_query_i; // RULE_11
      ql_q <= sync_query_i ? lock_q : ql_q; // RULE_11
    end
  end
  assign sync_locked_o = lock_q;
  assign status_show_synced_o = show_q;
  assign sync_query_valid_o = qv_q;
  assign sync_query_locked_o = ql_q;
  assign phase_a_o = acc_q;
  assign phase_b_o = pb_q;
  assign phase_c_o = pc_q;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_off_mode_enable: assert property ( // RULE_01
    cfg_i.il_mode == DIC_IL_OFF && enable_req_i && !disable_req_i
    |=> output_enable_o) else $error("off mode enable refused");
  a_gate_needs_short: assert property ( // RULE_02
    cfg_i.il_mode == DIC_IL_GATE && !output_enable_o && !il_s
    |=> !output_enable_o) else $error("gate enabled while open");
  a_gate_open_fault: assert property ( // RULE_03
    cfg_i.il_mode == DIC_IL_GATE && output_enable_o && !il_s
    |=> interlock_fault_o && !output_enable_o)
    else $error("open interlock missed");
  a_force_follow: assert property ( // RULE_04
    cfg_i.il_mode == DIC_IL_FORCE |=> output_enable_o == $past(il_s))
    else $error("force mode not following");
  a_trig_waits: assert property ( // RULE_06
    tr_q == DIC_TR_IDLE && transient_arm_i && cfg_i.trig_mode
    |=> transient_running_o && transient_progress_zero_o
    && !transient_start_o) else $error("arm did not wait");
  a_trig_starts: assert property ( // RULE_05
    tr_q == DIC_TR_WAIT && trig_rise && !transient_done_i
    |=> transient_start_o ##1 !transient_start_o
    && !transient_progress_zero_o) else $error("trigger start lost");
  a_trig_sync_delay: assert property ( // RULE_17
    trig_rise |-> $past(transient_trigger_input_i, 2))
    else $error("trigger bypassed synchronizer");
  a_sync_off_unlock: assert property ( // RULE_10
    $rose(cfg_i.sync_en) |=> !sync_locked_o [*2])
    else $error("locked without reacquisition");
  a_span_reset: assert property ( // RULE_08
    $rose(reset_n_i) |-> span_q == CAPTURE_SPAN_RST)
    else $error("span reset value wrong");
  a_query_answer: assert property ( // RULE_11
    sync_query_i |=> sync_query_valid_o
    && sync_query_locked_o == $past(sync_locked_o))
    else $error("query answer wrong");
  a_show_locked: assert property ( // RULE_12
    status_show_synced_o |-> sync_locked_o)
    else $error("synced shown while unlocked");
  a_phase_b_rel: assert property ( // RULE_07
    $past(reset_n_i) |-> phase_b_o == phase_a_o + $past(cfg_i.angle_b))
    else $error("phase B not tied to A");
  c_lock_reached: cover property ($rose(sync_locked_o));
  c_trig_start: cover property (tr_q == DIC_TR_WAIT && trig_rise);
  c_gate_fault: cover property ($rose(interlock_fault_o));
  c_show_synced: cover property ($fell(status_show_synced_o)
    && sync_locked_o);
endmodule

// ---- logic/dic_pkg.sv ----
package dic_pkg;
  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned DISP_PERIOD_S = 3;
  localparam int unsigned DISP_SHOW_S = 1;
  localparam int unsigned DISP_PERIOD_CYC = DISP_PERIOD_S * CLK_HZ;
  localparam int unsigned DISP_SHOW_CYC = DISP_SHOW_S * CLK_HZ;
  localparam int unsigned REF_FMIN_HZ = 15;
  localparam int unsigned REF_FMAX_HZ = 5000;
  // Longest legal reference period, rounded down
  localparam int unsigned REF_PMAX_CYC = CLK_HZ / REF_FMIN_HZ;
  // Shortest legal reference period, rounded up
  localparam int unsigned REF_PMIN_CYC =
    (CLK_HZ + REF_FMAX_HZ - 1) / REF_FMAX_HZ;
  // ----------------------------------------
  // Sync loop constants
  // ----------------------------------------
  localparam logic [15:0] CAPTURE_SPAN_RST = 16'h000A;
  localparam logic [3:0] LOCK_EDGES = 4'h8;
  localparam logic [31:0] LOCK_ERR_MAX = 32'h0100_0000;
  localparam logic [23:0] PERIOD_TOL = 24'h000040;
  // Phase increment per Hz, scaled by 2^INC_FRAC
  localparam logic [15:0] INC_PER_HZ = 16'h2AF3;
  localparam int unsigned INC_FRAC = 8;
  localparam logic [4:0] SHIFT_BASE = 5'h0C;
  localparam logic [4:0] PHASE_PULL = 5'h02;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    DIC_IL_OFF,
    DIC_IL_GATE,
    DIC_IL_FORCE
  } dic_il_mode_t;
  typedef enum logic [1:0] {
    DIC_TR_IDLE,
    DIC_TR_WAIT,
    DIC_TR_RUN
  } dic_tr_state_t;
  typedef struct packed {
    dic_il_mode_t il_mode;
    logic trig_mode;
    logic sync_en;
    logic [15:0] frequency_setpoint;
    logic [31:0] reference_phase_offset;
    logic [3:0] track_speed;
    logic [31:0] angle_b;
    logic [31:0] angle_c;
  } dic_cfg_t;
endpackage

// ---- verification/dic_ext_model.sv ----
// ----------------------------------------
// External equipment: contacts and sources
// ----------------------------------------
module dic_ext_model (
  input wire logic core_clk_i,
  input wire logic shorted_i,
  input wire logic trig_i,
  input wire logic ref_on_i,
  input wire logic [15:0] ref_half_i,
  output logic interlock_input_o,
  output logic transient_trigger_input_o,
  output logic sync_reference_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial begin
    interlock_input_o = 1'b0;
    transient_trigger_input_o = 1'b0;
    sync_reference_o = 1'b0;
  end
  // Pins move off the clock edge, as unrelated equipment would
  always @(posedge core_clk_i) begin
    #3;
    interlock_input_o = shorted_i;
    transient_trigger_input_o = trig_i;
    if (!ref_on_i) begin
      cnt = 0;
      sync_reference_o = 1'b0;
    end else if (cnt >= int'(ref_half_i) - 1) begin
      cnt = 0;
      sync_reference_o = !sync_reference_o;
    end else begin
      cnt = cnt + 1;
    end
  end
endmodule

// ---- verification/dic_dedicated_input_control_tb_top.sv ----
module dic_dedicated_input_control_tb_top;
  import dic_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0;
  dic_cfg_t cfg;
  logic [15:0] span = 16'h0000, lfsr = 16'h0040;
  logic span_wr = 1'b0, en_req = 1'b0, dis_req = 1'b0, f_clr = 1'b0;
  logic arm = 1'b0, done = 1'b0, query = 1'b0;
  logic shorted = 1'b0, trig = 1'b0, ref_on = 1'b0;
  logic il_pin, tr_pin, ref_pin, oe, fault, run, zero, start;
  logic locked, q_valid, q_locked, show;
  logic [31:0] ph_a, ph_b, ph_c;
  int miscompares = 0, tests_run = 0, cycles = 0, hits;
  always #5 clk = !clk;
  // ----------------------------------------
  // Far side and device
  // ----------------------------------------
  dic_ext_model u_ext (.core_clk_i(clk), .shorted_i(shorted),
    .trig_i(trig), .ref_on_i(ref_on), .ref_half_i(16'h03E8),
    .interlock_input_o(il_pin), .transient_trigger_input_o(tr_pin),
    .sync_reference_o(ref_pin));
  dic_dedicated_input_control #(.DISP_PERIOD_C(30), .DISP_SHOW_C(10),
    .REF_PMAX_C(4000), .REF_PMIN_C(20)) u_dut (
    .core_clk_i(clk), .reset_n_i(rst_n), .cfg_i(cfg),
    .capture_span_i(span), .capture_span_wr_i(span_wr),
    .interlock_input_i(il_pin), .transient_trigger_input_i(tr_pin),
    .sync_reference_i(ref_pin), .enable_req_i(en_req),
    .disable_req_i(dis_req), .fault_clear_i(f_clr),
    .transient_arm_i(arm), .transient_done_i(done),
    .sync_query_i(query), .output_enable_o(oe),
    .interlock_fault_o(fault), .transient_running_o(run),
    .transient_progress_zero_o(zero), .transient_start_o(start),
    .sync_locked_o(locked), .sync_query_valid_o(q_valid),
    .sync_query_locked_o(q_locked), .status_show_synced_o(show),
    .phase_a_o(ph_a), .phase_b_o(ph_b), .phase_c_o(ph_c));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] next_lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [31:0] exp_phase(input logic [31:0] a,
                                            input logic [31:0] ang);
    return a + ang;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_lock(input int lim);
    for (int i = 0; i < lim && locked !== 1'b1; i++) step(1);
  endtask
  task automatic wrap_up();
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 95000) begin
      miscompares++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    cfg = '0;
    cfg.track_speed = 4'h0; // Slow loop, setpoint sits near reference
    cfg.frequency_setpoint = 16'hC345;
    step(20);
    rst_n = 1'b1;
    // Off mode: open pin, eight random enable or disable pulses
    for (int i = 0; i < 8; i++) begin
      lfsr = next_lfsr(lfsr);
      if (lfsr[0]) pulse(en_req);
      else pulse(dis_req);
      chk(oe, lfsr[0]);
      step(1);
    end
    pulse(dis_req);
    // Gate mode: open refuses, open while on faults
    cfg.il_mode = DIC_IL_GATE;
    pulse(en_req);
    chk(oe, 0);
    shorted = 1'b1;
    step(4);
    pulse(en_req);
    chk(oe, 1);
    shorted = 1'b0;
    step(6);
    chk({oe, fault}, 2'b01);
    shorted = 1'b1;
    step(4);
    pulse(en_req);
    chk(oe, 0);
    pulse(f_clr);
    chk(fault, 0);
    pulse(en_req);
    chk(oe, 1);
    pulse(dis_req);
    // Force mode: pin decides, requests do not
    shorted = 1'b0;
    cfg.il_mode = DIC_IL_FORCE;
    step(5);
    pulse(en_req);
    chk(oe, 0);
    shorted = 1'b1;
    step(6);
    pulse(dis_req);
    chk(oe, 1);
    shorted = 1'b0;
    step(6);
    chk(oe, 0);
    // Armed transient waits for trigger rise, or starts at once with trig_mode off
    cfg.trig_mode = 1'b1;
    pulse(arm);
    chk({run, zero, start}, 3'b110);
    step(5);
    chk({run, zero, start}, 3'b110);
    trig = 1'b1;
    hits = 0;
    for (int i = 0; i < 8; i++) begin
      step(1);
      if (start === 1'b1) hits++;
    end
    chk(hits, 1);
    chk({run, zero}, 2'b10);
    pulse(done);
    chk(run, 0);
    trig = 1'b0;
    cfg.trig_mode = 1'b0;
    pulse(arm);
    chk({run, start}, 2'b11);
    pulse(done);
    // Phases B and C keep their angles to A
    lfsr = next_lfsr(lfsr);
    cfg.angle_b = {lfsr, 16'h5555};
    lfsr = next_lfsr(lfsr);
    cfg.angle_c = {16'hAAAA, lfsr};
    step(2);
    chk(ph_b, exp_phase(ph_a, cfg.angle_b));
    chk(ph_c, exp_phase(ph_a, cfg.angle_c));
    // Reference outside default span never locks
    ref_on = 1'b1;
    cfg.sync_en = 1'b1;
    step(1);
    chk(locked, 0);
    step(1);
    chk(locked, 0);
    step(10000);
    chk(locked, 0);
    chk(oe, 0);
    pulse(query);
    chk({q_valid, q_locked}, 2'b10);
    // Wider span lets the loop acquire
    span = 16'h00C8;
    pulse(span_wr);
    wait_lock(60000);
    chk(locked, 1);
    pulse(query);
    chk({q_valid, q_locked}, 2'b11);
    chk(ph_b, exp_phase(ph_a, cfg.angle_b));
    hits = 0;
    for (int i = 0; i < 30; i++) begin
      step(1);
      if (show === 1'b1) hits++;
    end
    chk(hits, 10);
    cfg.sync_en = 1'b0;
    step(3);
    chk({locked, show}, 2'b00);
    // Mid-run reset clears state and restores the span
    rst_n = 1'b0;
    step(3);
    rst_n = 1'b1;
    step(2);
    chk({oe, fault, run, zero, start, locked, q_valid, show}, 8'h00);
    wrap_up();
  end
endmodule
